// ---- swb_exec.sv ----
// Purpose: apb-controlled execution of subtract memory from accumulator
//          with borrow, with working register, flags and data memory
// Assumes: apb master holds the request until pready
// Notes:   an instruction takes one read and one execute cycle
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
module swb_exec #(
  parameter int AW = 12  // data space address width
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // ********************************************************************
  // state
  // ********************************************************************
  swb_pkg::swb_state_t state_r, state_nxt;        // execution sequence
  logic [15:0]         instr_r, instr_nxt;        // last instruction word
  logic [7:0]          w_r, w_nxt;                // working register
  logic [4:0]          status_r, status_nxt;      // arithmetic flags
  logic [3:0]          bank_r, bank_nxt;          // bank select register
  logic [11:0]         ibase_r, ibase_nxt;        // index base
  logic                ext_r, ext_nxt;            // extended set enable
  logic                bad_r, bad_nxt;            // unsupported opcode seen
  logic [AW-1:0]       maddr_r, maddr_nxt;        // memory window address
  logic [AW-1:0]       exaddr_r, exaddr_nxt;      // resolved operand address
  logic                settle_r, settle_nxt;      // window read data valid

  // ********************************************************************
  // combinational helpers
  // ********************************************************************
  logic                access;                    // apb access phase
  logic                xfer;                      // access completing now
  logic                wr;                        // completing write
  logic                hit;                       // mapped offset
  logic [AW-1:0]       res_addr;                  // resolver output
  logic                res_indexed;               // resolver used index mode
  logic [7:0]          mem_rdata;                 // operand byte
  logic                mem_we;                    // memory write strobe
  logic [AW-1:0]       mem_addr;                  // memory port address
  logic [7:0]          mem_wdata;                 // memory write byte
  logic [12:0]         sub_out;                   // flags and result
  logic [7:0]          sub_res;                   // subtraction result

  // pready stays low while the sequence owns the memory port and for one
  // cycle after the window moves, so a window read never returns a stale byte
  assign access  = psel && penable;
  assign pready  = (state_r == swb_pkg::ST_IDLE) && settle_r;
  assign xfer    = access && pready;
  assign wr      = xfer && pwrite;
  assign sub_out = swb_pkg::sub_borrow(w_r, mem_rdata, status_r[swb_pkg::ST_C]);
  assign sub_res = sub_out[7:0];

  // offset decode, anything else answers with an error
  always_comb begin
    unique case (paddr)
      swb_pkg::OFF_CTRL, swb_pkg::OFF_WREG, swb_pkg::OFF_STATUS,
      swb_pkg::OFF_BANK, swb_pkg::OFF_IBASE, swb_pkg::OFF_INSTR,
      swb_pkg::OFF_MADDR, swb_pkg::OFF_MDATA, swb_pkg::OFF_LADDR: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = xfer && !hit;

  // ********************************************************************
  // operand address and data memory
  // ********************************************************************
  // resolver is combinational; its result is kept in exaddr_r for write-back
  swb_addr u_swb_addr (
    .f_addr     (instr_r[7:0]),
    .bank_bit   (instr_r[swb_pkg::OP_A]),
    .ext_en     (ext_r),
    .bank_sel   (bank_r),
    .index_base (ibase_r),
    .addr       (res_addr),
    .indexed    (res_indexed)
  );

  // port mux: sequence owns the port while busy, the window otherwise
  always_comb begin
    mem_addr  = maddr_r;
    mem_we    = 1'b0;
    mem_wdata = pwdata[7:0];
    unique case (state_r)
      swb_pkg::ST_READ: mem_addr = res_addr;
      swb_pkg::ST_EXEC: begin
        mem_addr  = exaddr_r;
        mem_we    = instr_r[swb_pkg::OP_D];
        mem_wdata = sub_res;
      end
      swb_pkg::ST_IDLE: mem_we = wr && (paddr == swb_pkg::OFF_MDATA);
    endcase
  end

  swb_mem #(
    .AW (AW),
    .DW (8)
  ) u_swb_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_r (mem_rdata)
  );

  // ********************************************************************
  // next-state logic
  // ********************************************************************
  always_comb begin
    state_nxt  = state_r;
    instr_nxt  = instr_r;
    w_nxt      = w_r;
    status_nxt = status_r;
    bank_nxt   = bank_r;
    ibase_nxt  = ibase_r;
    ext_nxt    = ext_r;
    bad_nxt    = bad_r;
    maddr_nxt  = maddr_r;
    exaddr_nxt = exaddr_r;
    unique case (state_r)
      swb_pkg::ST_IDLE: begin
        if (wr) begin
          unique case (paddr)
            swb_pkg::OFF_CTRL: begin
              ext_nxt = pwdata[swb_pkg::CTRL_EXT];
              // write one clears; no event can land in the same cycle
              if (pwdata[swb_pkg::CTRL_BAD]) begin
                bad_nxt = 1'b0;
              end
            end
            swb_pkg::OFF_WREG:   w_nxt      = pwdata[7:0];
            swb_pkg::OFF_STATUS: status_nxt = pwdata[4:0];
            swb_pkg::OFF_BANK:   bank_nxt   = pwdata[3:0];
            swb_pkg::OFF_IBASE:  ibase_nxt  = pwdata[11:0];
            swb_pkg::OFF_MADDR:  maddr_nxt  = pwdata[AW-1:0];
            swb_pkg::OFF_INSTR: begin
              instr_nxt = pwdata[15:0];
              if (swb_pkg::is_sub_op(pwdata[15:0])) begin
                state_nxt = swb_pkg::ST_READ;
              end else begin
                bad_nxt = 1'b1;   // other opcodes are not executed here
              end
            end
            default: ;             // window data goes through the port mux; read-only or unmapped, no effect
          endcase
        end
      end
      swb_pkg::ST_READ: begin
        exaddr_nxt = res_addr;    // kept for the write-back cycle
        state_nxt  = swb_pkg::ST_EXEC;
      end
      swb_pkg::ST_EXEC: begin
        if (!instr_r[swb_pkg::OP_D]) begin
          w_nxt = sub_res;
        end
        status_nxt = sub_out[12:8];
        state_nxt  = swb_pkg::ST_IDLE;
      end
    endcase
  end

  // window data is valid once the port has held the window address a cycle
  // trade-off: one wait state instead of a bypass path from the write data
  assign settle_nxt = (state_r == swb_pkg::ST_IDLE) && !mem_we && !(wr && (paddr == swb_pkg::OFF_MADDR));

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= swb_pkg::ST_IDLE;
      instr_r  <= 16'h0000;
      w_r      <= swb_pkg::RST_WREG;
      status_r <= swb_pkg::RST_STATUS;
      bank_r   <= swb_pkg::RST_BANK;
      ibase_r  <= swb_pkg::RST_IBASE;
      ext_r    <= 1'b0;
      bad_r    <= 1'b0;
      maddr_r  <= '0;
      exaddr_r <= '0;
      settle_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      instr_r  <= instr_nxt;
      w_r      <= w_nxt;
      status_r <= status_nxt;
      bank_r   <= bank_nxt;
      ibase_r  <= ibase_nxt;
      ext_r    <= ext_nxt;
      bad_r    <= bad_nxt;
      maddr_r  <= maddr_nxt;
      exaddr_r <= exaddr_nxt;
      settle_r <= settle_nxt;
    end
  end

  // ********************************************************************
  // read data
  // ********************************************************************
  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      unique case (paddr)
        swb_pkg::OFF_CTRL: begin
          prdata[swb_pkg::CTRL_EXT]  = ext_r;
          prdata[swb_pkg::CTRL_BUSY] = (state_r != swb_pkg::ST_IDLE);
          prdata[swb_pkg::CTRL_BAD]  = bad_r;
        end
        swb_pkg::OFF_WREG:   prdata[7:0]    = w_r;
        swb_pkg::OFF_STATUS: prdata[4:0]    = status_r;
        swb_pkg::OFF_BANK:   prdata[3:0]    = bank_r;
        swb_pkg::OFF_IBASE:  prdata[11:0]   = ibase_r;
        swb_pkg::OFF_INSTR:  prdata[15:0]   = instr_r;
        swb_pkg::OFF_MADDR:  prdata[AW-1:0] = maddr_r;
        swb_pkg::OFF_MDATA:  prdata[7:0]    = mem_rdata;
        swb_pkg::OFF_LADDR:  prdata[AW-1:0] = exaddr_r;
        default: ;               // unmapped reads as zero
      endcase
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_result_value: assert property ((state_r == swb_pkg::ST_EXEC) |->
    sub_res == 8'(w_r - mem_rdata - {7'h00, ~status_r[swb_pkg::ST_C]}))
    else $error("subtraction result wrong");

  a_dest_wreg: assert property ((state_r == swb_pkg::ST_EXEC && !instr_r[swb_pkg::OP_D]) |->
    !mem_we ##1 (w_r == $past(sub_res)))
    else $error("working register destination wrong");

  a_dest_mem: assert property ((state_r == swb_pkg::ST_EXEC && instr_r[swb_pkg::OP_D]) |->
    (mem_we && mem_wdata == sub_res) ##1 (w_r == $past(w_r)))
    else $error("memory destination wrong");

  a_access_bank: assert property ((state_r == swb_pkg::ST_READ && !instr_r[swb_pkg::OP_A] &&
    !(ext_r && instr_r[7:0] <= swb_pkg::ACCESS_SPLIT)) |->
    mem_addr == ((instr_r[7:0] <= swb_pkg::ACCESS_SPLIT) ? {4'h0, instr_r[7:0]} :
                 {swb_pkg::ACCESS_HIGH_BANK, instr_r[7:0]}))
    else $error("access bank address wrong");

  a_bank_select: assert property ((state_r == swb_pkg::ST_READ && instr_r[swb_pkg::OP_A]) |=>
    exaddr_r == {$past(bank_r), $past(instr_r[7:0])})
    else $error("bank select address wrong");

  a_indexed_mode: assert property ((state_r == swb_pkg::ST_READ && !instr_r[swb_pkg::OP_A] && ext_r &&
    instr_r[7:0] <= swb_pkg::ACCESS_SPLIT) |-> res_indexed && mem_addr == 12'(ibase_r + {4'h0, instr_r[7:0]}))
    else $error("indexed literal offset address wrong");

  a_carry_borrow: assert property ((state_r == swb_pkg::ST_EXEC) |=>
    status_r[swb_pkg::ST_C] == ($past(w_r) >= 9'($past(mem_rdata)) + 9'($past(~status_r[swb_pkg::ST_C]))) &&
    status_r[swb_pkg::ST_Z] == ($past(sub_res) == 8'h00) && status_r[swb_pkg::ST_N] == $past(sub_res[7]))
    else $error("flags wrong after subtract");

  // read, execute and one settle cycle, then the bus is free again
  a_busy_stall: assert property ((wr && paddr == swb_pkg::OFF_INSTR && swb_pkg::is_sub_op(pwdata[15:0])) |=>
    !pready [*3] ##1 pready)
    else $error("instruction sequence length wrong");

  // sign-extended difference; bits 8 and 7 disagree exactly on signed overflow
  logic [8:0]          chk_sdiff;                 // overflow reference
  assign chk_sdiff = {w_r[7], w_r} - {mem_rdata[7], mem_rdata} - {8'h00, ~status_r[swb_pkg::ST_C]};

  // digit carry and overflow, from a reference independent of the adder
  a_flag_digit: assert property ((state_r == swb_pkg::ST_EXEC) |=>
    status_r[swb_pkg::ST_DIGIT] ==
    ({1'b0, $past(w_r[3:0])} >= 5'($past(mem_rdata[3:0])) + 5'($past(~status_r[swb_pkg::ST_C]))))
    else $error("digit carry wrong after subtract");

  a_flag_overflow: assert property ((state_r == swb_pkg::ST_EXEC) |=>
    status_r[swb_pkg::ST_OVER] == ($past(chk_sdiff[8]) != $past(chk_sdiff[7])))
    else $error("overflow flag wrong after subtract");

  // only misaligned or out-of-map offsets may answer with an error
  a_unmapped_err: assert property ((access && pready) |->
    (pslverr == (paddr[1:0] != 2'h0 || paddr > swb_pkg::OFF_LADDR)))
    else $error("error answer does not match the offset");

  // flags and working register hold while the operand is being read; only exaddr_r takes the resolved address
  a_read_holds: assert property ((state_r == swb_pkg::ST_READ) |=>
    $stable(status_r) && $stable(w_r))
    else $error("flags or working register changed before execute");

endmodule

// ---- swb_pkg.sv ----
// Purpose: shared constants, state codes and the subtract function for the
//          subtract-with-borrow execution unit
// Assumes: 32-bit apb data, byte addresses, one aligned word per register
// Notes:   nothing here holds state
package swb_pkg;

  // ********************************************************************
  // register offsets (byte addresses)
  // ********************************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00; // control and sticky status
  localparam logic [7:0] OFF_WREG   = 8'h04; // working register
  localparam logic [7:0] OFF_STATUS = 8'h08; // arithmetic flags
  localparam logic [7:0] OFF_BANK   = 8'h0C; // bank select register
  localparam logic [7:0] OFF_IBASE  = 8'h10; // index base for literal offset mode
  localparam logic [7:0] OFF_INSTR  = 8'h14; // instruction word, write executes
  localparam logic [7:0] OFF_MADDR  = 8'h18; // memory window address
  localparam logic [7:0] OFF_MDATA  = 8'h1C; // memory window data
  localparam logic [7:0] OFF_LADDR  = 8'h20; // last resolved operand address

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int CTRL_EXT  = 0;  // extended instruction set enable
  localparam int CTRL_BUSY = 1;  // instruction in flight, read only
  localparam int CTRL_BAD  = 2;  // unsupported opcode seen, write one to clear
  localparam int ST_C      = 0;  // carry, set means no borrow
  localparam int ST_DIGIT  = 1;  // digit carry
  localparam int ST_Z      = 2;  // zero
  localparam int ST_OVER   = 3;  // overflow
  localparam int ST_N      = 4;  // negative
  localparam int OP_D      = 9;  // destination select bit of the instruction
  localparam int OP_A      = 8;  // bank access bit of the instruction

  // ********************************************************************
  // encodings and reset values
  // ********************************************************************
  localparam logic [5:0] OPC_SUB_MEM_BORROW = 6'h15;  // top six opcode bits
  localparam logic [7:0] ACCESS_SPLIT       = 8'h5F;  // last low access-bank byte
  localparam logic [3:0] ACCESS_HIGH_BANK   = 4'hF;   // bank of the upper access half
  localparam logic [7:0] RST_WREG           = 8'h00;
  localparam logic [4:0] RST_STATUS         = 5'h00;
  localparam logic [3:0] RST_BANK           = 4'h0;
  localparam logic [11:0] RST_IBASE         = 12'h000;

  // execution sequence, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,   // waiting for an instruction
    ST_READ = 3'h2,   // operand address on the memory port
    ST_EXEC = 3'h4    // operand valid, result written
  } swb_state_t;

  // true for the subtract-memory-from-accumulator-with-borrow opcode
  function automatic logic is_sub_op(input logic [15:0] instr);
    is_sub_op = (instr[15:10] == OPC_SUB_MEM_BORROW);
  endfunction

  // returns {neg, overflow, zero, digit, carry, result[7:0]}
  function automatic logic [12:0] sub_borrow(input logic [7:0] w, input logic [7:0] f, input logic c);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] res;
    logic       ovf;
    full = {1'b0, w} - {1'b0, f} - {8'h00, ~c};
    low  = {1'b0, w[3:0]} - {1'b0, f[3:0]} - {4'h0, ~c};
    res  = full[7:0];
    ovf  = (w[7] != f[7]) && (res[7] != w[7]);
    sub_borrow = {res[7], ovf, (res == 8'h00), ~low[4], ~full[8], res};
  endfunction

endpackage

// ---- swb_mem.sv ----
// Purpose: byte-wide data memory with registered read data
// Assumes: one port, write and read share the address
// Notes:   read during write returns the old byte
`timescale 1ns/10ps
module swb_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [0:(1<<AW)-1];  // storage, no reset on purpose

  // storage write, no reset so it maps onto ram
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[addr];
    end
  end

endmodule

// ---- swb_addr.sv ----
// Purpose: operand address resolution for byte-oriented instructions
// Assumes: 12-bit data space, 256-byte banks
// Notes:   purely combinational; the caller registers what it keeps
`timescale 1ns/10ps
module swb_addr (
  // instruction fields
  input  wire logic [7:0]  f_addr,
  input  wire logic        bank_bit,
  // configuration
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank_sel,
  input  wire logic [11:0] index_base,
  // resolved address
  output logic      [11:0] addr,
  output logic             indexed
);

  // ********************************************************************
  // bank and mode selection
  // ********************************************************************
  always_comb begin
    indexed = 1'b0;
    if (bank_bit) begin
      addr = {bank_sel, f_addr};
    end else if (ext_en && (f_addr <= swb_pkg::ACCESS_SPLIT)) begin
      // offset from the index base, wraps inside the data space
      addr    = index_base + {4'h0, f_addr};
      indexed = 1'b1;
    end else if (f_addr <= swb_pkg::ACCESS_SPLIT) begin
      addr = {4'h0, f_addr};
    end else begin
      addr = {swb_pkg::ACCESS_HIGH_BANK, f_addr};
    end
  end

endmodule

// ---- swb_exec_tb.sv ----
// Purpose: self-checking bench for the subtract-with-borrow execution unit
// Assumes: apb master drives on the rising edge, slave answers via pready
// Notes:   every expectation is worked out here, never read back from the design
`timescale 1ns/10ps
module swb_exec_tb;

  // ********************************************************************
  // signals and counters
  // ********************************************************************
  logic        pclk;      // 20 mhz bus clock
  logic        presetn;   // async reset, active low
  logic        psel;      // apb select
  logic        penable;   // apb access phase
  logic        pwrite;    // apb direction
  logic [7:0]  paddr;     // byte address
  logic [31:0] pwdata;    // write data
  logic [31:0] prdata;    // read data
  logic        pready;    // slave answer
  logic        pslverr;   // slave error
  int          bad_count; // mismatches
  int          checked;   // comparisons made

  localparam logic [3:0]  TB_BANK  = 4'h3;    // bank select used by the cases with the bank access bit set
  localparam logic [11:0] TB_IBASE = 12'h200; // index base for literal offset mode

  // ********************************************************************
  // design under test
  // ********************************************************************
  swb_exec #(.AW(12)) u_swb_exec (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // free-running clock, 50 ns period
  always #25 pclk = ~pclk;

  // ********************************************************************
  // closing and comparison tasks
  // ********************************************************************
  // single place where the run ends
  task automatic stop_test();
    $display("counts: checked %0d, bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // word compare, case equality so unknowns never match
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // single-bit compare
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %b seen %b", what, exp, got);
    end
  endtask

  // ********************************************************************
  // apb master
  // ********************************************************************
  // one transfer; the leading edge keeps psel from being driven twice in a step
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // busy stalls pready; only the watchdog ends a wait that never finishes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // plain write, error must stay low on mapped offsets
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd_v;
    logic        e;
    apb_xfer(1'b1, a, d, rd_v, e);
    chk_bit("pslverr on write", 1'b0, e);
  endtask

  // plain read, returns data and error flag
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic e);
    apb_xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask

  // ********************************************************************
  // reference arithmetic and addressing
  // ********************************************************************
  // returns {neg, overflow, zero, digit, carry, result}, from signed integer sums
  function automatic logic [12:0] ref_sub(input logic [7:0] w, input logic [7:0] f, input logic c);
    int b;
    int u;
    int lo;
    int s;
    logic [7:0] r;
    b  = c ? 0 : 1;
    u  = int'(w) - int'(f) - b;
    lo = int'(w[3:0]) - int'(f[3:0]) - b;
    s  = int'($signed(w)) - int'($signed(f)) - b;
    r  = u[7:0];
    ref_sub = {r[7], (s > 127 || s < -128), (r == 8'h00), (lo >= 0), (u >= 0), r};
  endfunction

  // resolved 12-bit operand address for the bank and mode bits
  function automatic logic [11:0] ref_addr(input logic a, input logic [7:0] fa, input logic ext);
    if (a) begin
      ref_addr = {TB_BANK, fa};
    end else if (fa <= 8'h5F) begin
      ref_addr = ext ? (TB_IBASE + {4'h0, fa}) : {4'h0, fa};
    end else begin
      ref_addr = {4'hF, fa};
    end
  endfunction

  // one instruction: preload operand, w and carry, execute, read everything back
  task automatic run_case(input logic [7:0] w, input logic [7:0] f, input logic c,
                          input logic d, input logic a, input logic [7:0] fa, input logic ext);
    logic [11:0] ad;
    logic [12:0] e;
    logic [31:0] v;
    logic        er;
    ad = ref_addr(a, fa, ext);
    e  = ref_sub(w, f, c);
    wr(swb_pkg::OFF_CTRL, {31'h0, ext});
    wr(swb_pkg::OFF_MADDR, {20'h0, ad});
    wr(swb_pkg::OFF_MDATA, {24'h0, f});
    wr(swb_pkg::OFF_WREG, {24'h0, w});
    wr(swb_pkg::OFF_STATUS, {31'h0, c});
    wr(swb_pkg::OFF_INSTR, {16'h0, swb_pkg::OPC_SUB_MEM_BORROW, d, a, fa});
    rd(swb_pkg::OFF_WREG, v, er);
    chk("wreg", {24'h0, d ? w : e[7:0]}, v);
    rd(swb_pkg::OFF_MDATA, v, er);
    chk("memory byte", {24'h0, d ? e[7:0] : f}, v);
    rd(swb_pkg::OFF_STATUS, v, er);
    chk("status", {27'h0, e[12:8]}, v);
    rd(swb_pkg::OFF_LADDR, v, er);
    chk("operand address", {20'h0, ad}, v);
  endtask

  // ********************************************************************
  // watchdog
  // ********************************************************************
  // the tests need well under 1500 cycles
  initial begin
    #(6000 * 50);
    bad_count++;
    $display("wrong value watchdog: expected finish seen timeout");
    stop_test();
  end

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    logic [31:0] v;
    logic        er;
    pclk      = 1'b0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    bad_count = 0;
    checked   = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;

    // reset values and an unmapped offset
    rd(swb_pkg::OFF_WREG, v, er);
    chk("wreg reset", 32'h0000_0000, v);
    rd(swb_pkg::OFF_STATUS, v, er);
    chk("status reset", 32'h0000_0000, v);
    rd(swb_pkg::OFF_CTRL, v, er);
    chk("ctrl reset", 32'h0000_0000, v);
    rd(8'h40, v, er);
    chk_bit("pslverr unmapped", 1'b1, er);
    chk("unmapped data", 32'h0000_0000, v);
    $display("test reset done");

    // other opcodes only raise the sticky flag, write one clears it
    wr(swb_pkg::OFF_BANK, {28'h0, TB_BANK});
    wr(swb_pkg::OFF_IBASE, {20'h0, TB_IBASE});
    wr(swb_pkg::OFF_INSTR, 32'h0000_1234);
    rd(swb_pkg::OFF_CTRL, v, er);
    chk("ctrl bad opcode", 32'h0000_0004, v);
    rd(swb_pkg::OFF_WREG, v, er);
    chk("wreg untouched", 32'h0000_0000, v);
    wr(swb_pkg::OFF_CTRL, 32'h0000_0004);
    rd(swb_pkg::OFF_CTRL, v, er);
    chk("ctrl cleared", 32'h0000_0000, v);
    $display("test opcode done");

    // arithmetic, destinations and every addressing path, boundary 5F/60
    run_case(8'h02, 8'h03, 1'b1, 1'b1, 1'b0, 8'h10, 1'b0);
    run_case(8'h05, 8'h02, 1'b1, 1'b0, 1'b1, 8'h20, 1'b0);
    run_case(8'h02, 8'h01, 1'b0, 1'b1, 1'b0, 8'h70, 1'b0);
    run_case(8'h80, 8'h01, 1'b1, 1'b1, 1'b0, 8'h5F, 1'b1);
    run_case(8'h35, 8'h12, 1'b0, 1'b0, 1'b0, 8'h60, 1'b1);
    run_case(8'h7F, 8'hFF, 1'b1, 1'b1, 1'b1, 8'hFF, 1'b1);
    $display("test execute done");

    // last resolved address is read only
    wr(swb_pkg::OFF_LADDR, 32'h0000_0ABC);
    rd(swb_pkg::OFF_LADDR, v, er);
    chk("laddr read only", 32'h0000_03FF, v);
    $display("test read only done");
    stop_test();
  end

endmodule
